// File: core/sch_line_if.sv
// Synchronised modem lines and millisecond tick between sequencer modules
`timescale 1ns/1ps
interface sch_line_if;
  logic dcd;
  logic dsr;
  logic ri;
  logic ms_tick;
  modport src (output dcd, output dsr, output ri, output ms_tick);
  modport snk (input dcd, input dsr, input ri, input ms_tick);
endinterface

// File: core/sch_line_sync.sv
// Pin synchronisers and millisecond prescaler
`timescale 1ns/1ps
module sch_line_sync #(
  parameter int unsigned MS_CYCLES = sch_pkg::MS_CYCLES
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic [sch_pkg::SYNC_N-1:0] pins,
  sch_line_if.src                     lin
);

  // ----------------------------------------------------------------
  // Two-stage synchronisers
  // ----------------------------------------------------------------
  logic [sch_pkg::SYNC_N-1:0] s1_q;
  logic [sch_pkg::SYNC_N-1:0] s2_q;
  logic [sch_pkg::SYNC_N-1:0] s1_d;
  logic [sch_pkg::SYNC_N-1:0] s2_d;

  always_comb begin
    s1_d = pins;
    s2_d = s1_q;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  logic [sch_pkg::PRE_W-1:0] pre_q;
  logic [sch_pkg::PRE_W-1:0] pre_d;
  logic                      tick_q;
  logic                      tick_d;

  always_comb begin
    tick_d = (pre_q == sch_pkg::PRE_W'(MS_CYCLES - 1));
    pre_d  = tick_d ? '0 : pre_q + 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      tick_q <= tick_d;
    end
  end

  assign lin.dcd     = s2_q[0];
  assign lin.dsr     = s2_q[1];
  assign lin.ri      = s2_q[2];
  assign lin.ms_tick = tick_q;

endmodule

// File: core/sch_pkg.sv
// Constants, states and mode codes of the call handshake sequencer
// Overview of operation
// - Hotline ring requests automatic data module call
// - Non-forced hotline raises DTR only on answer
// - Hotline: no DCD within 35 s disconnects
// - Mode 2 holds DTR high except release
// - Forced release: DTR low 0.2 s, then high
// - Forced modes: ignore ring and DCD two seconds after release
// - Mode 3: forced-DTR hotline, mode 2 release
// - Gateway raising DCD gets DTR asserted
// - Gateway: DSR optional, DSR or DCD fall disconnects
// - Inbound gateway call: first return character triggers autobaud
// - Local call to gateway answered, DTR raised
// - Outbound gateway: no DCD in 35 s releases
// - Local drop in gateway mode lowers DTR
// - Long break or three short breaks end call
// - DCD low 100 ms releases gateway call
// - DSR low 100 ms releases gateway call
// - Modem pooling: local drop or breaks lower DTR
// - Modem pooling: DCD/DSR drop after 100 ms releases
package sch_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned MS_PS         = 1000000000;
  localparam int unsigned MS_CYCLES     = MS_PS / CLK_PERIOD_PS;
  localparam int unsigned PRE_W         = 18;
  localparam int unsigned MS_W          = 16;
  localparam int unsigned QUAL_W        = 7;

  localparam logic [MS_W-1:0]   DCD_WAIT_MS  = 16'h88B8; // 35000 ms
  localparam logic [MS_W-1:0]   DTR_LOW_MS   = 16'h00C8; // 200 ms
  localparam logic [MS_W-1:0]   GUARD_MS     = 16'h07D0; // 2000 ms
  localparam logic [MS_W-1:0]   MS_SAT       = 16'hFFFF;
  localparam logic [QUAL_W-1:0] QUAL_MS      = 7'h64;    // 100 ms
  localparam logic [1:0]        SHORT_BRK_N  = 2'h3;
  localparam int unsigned       SYNC_N       = 3;

  // ----------------------------------------------------------------
  // Operation modes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_POOL      = 4'h0;
  localparam logic [3:0] MODE_HOT       = 4'h1;
  localparam logic [3:0] MODE_POOL_FRC  = 4'h2;
  localparam logic [3:0] MODE_HOT_FRC   = 4'h3;
  localparam logic [3:0] MODE_GATEWAY   = 4'h4;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DIAL,
    ST_WAIT_DCD,
    ST_UP,
    ST_DTR_LOW,
    ST_GUARD
  } sch_state_t;

endpackage

// File: core/sch_sequencer.sv
// Control-line call sequencer for the serial interface line card
`timescale 1ns/1ps
module sch_sequencer #(
  parameter int unsigned MS_CYCLES = sch_pkg::MS_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] mode,
  input  wire logic       dcd_pin,
  input  wire logic       dsr_pin,
  input  wire logic       ri_pin,
  input  wire logic       local_call,
  input  wire logic       local_answer,
  input  wire logic       local_drop,
  input  wire logic       break_long,
  input  wire logic       break_short,
  input  wire logic       cr_rx,
  output logic            dtr,
  output logic            hotline_req,
  output logic            call_answer,
  output logic            call_release,
  output logic            call_up,
  output logic            autobaud_req
);

  // ----------------------------------------------------------------
  // Line conditioning
  // ----------------------------------------------------------------
  sch_line_if lin ();

  sch_line_sync #(
    .MS_CYCLES (MS_CYCLES)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pins    ({ri_pin, dsr_pin, dcd_pin}),
    .lin     (lin)
  );

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic forced;
  logic hotline;
  logic gateway;

  always_comb begin
    forced  = (mode == sch_pkg::MODE_POOL_FRC) || (mode == sch_pkg::MODE_HOT_FRC);
    hotline = (mode == sch_pkg::MODE_HOT) || (mode == sch_pkg::MODE_HOT_FRC);
    gateway = (mode == sch_pkg::MODE_GATEWAY);
  end

  // ----------------------------------------------------------------
  // Edge history of synchronised lines
  // ----------------------------------------------------------------
  logic [2:0] prev_q;
  logic [2:0] prev_d;
  logic [2:0] lvl;
  logic       ri_rise;
  logic       dcd_rise;

  always_comb begin
    lvl      = {lin.ri, lin.dsr, lin.dcd};
    prev_d   = lvl;
    ri_rise  = lvl[2] && !prev_q[2];
    dcd_rise = lvl[0] && !prev_q[0];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= '0;
    end else begin
      prev_q <= prev_d;
    end
  end

  // ----------------------------------------------------------------
  // State registers declared ahead of the qualifiers
  // ----------------------------------------------------------------
  sch_pkg::sch_state_t st_q;
  sch_pkg::sch_state_t st_d;
  logic                qual_run;

  always_comb begin
    qual_run = (st_q == sch_pkg::ST_WAIT_DCD) || (st_q == sch_pkg::ST_UP);
  end

  // ----------------------------------------------------------------
  // Drop qualifiers for DCD (0) and DSR (1)
  // ----------------------------------------------------------------
  logic [1:0] line_drop;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_qual
      logic [sch_pkg::QUAL_W-1:0] hi_q;
      logic [sch_pkg::QUAL_W-1:0] hi_d;
      logic [sch_pkg::QUAL_W-1:0] lo_q;
      logic [sch_pkg::QUAL_W-1:0] lo_d;
      logic                       seen_q;
      logic                       seen_d;
      logic                       fall;
      logic                       drop;

      always_comb begin
        fall   = prev_q[gi] && !lvl[gi];
        hi_d   = hi_q;
        lo_d   = lo_q;
        seen_d = seen_q;
        if (!qual_run) begin
          hi_d   = '0;
          lo_d   = '0;
          seen_d = 1'b0;
        end else if (lvl[gi]) begin
          seen_d = 1'b1;
          lo_d   = '0;
          if (lin.ms_tick && hi_q != sch_pkg::QUAL_MS) begin
            hi_d = hi_q + 1'b1;
          end
        end else begin
          // Count held through the fall cycle so the drop test still sees it
          hi_d = fall ? hi_q : '0;
          if (lin.ms_tick && lo_q != sch_pkg::QUAL_MS) begin
            lo_d = lo_q + 1'b1;
          end
        end
        if (gateway) begin
          // DSR never raised is not a drop: the gateway need not assert it
          drop = seen_q && (lo_q == sch_pkg::QUAL_MS);
        end else begin
          drop = fall && (hi_q == sch_pkg::QUAL_MS);
        end
      end

      // One driver per bit, outside the per-lane process
      assign line_drop[gi] = drop;

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          hi_q   <= '0;
          lo_q   <= '0;
          seen_q <= 1'b0;
        end else begin
          hi_q   <= hi_d;
          lo_q   <= lo_d;
          seen_q <= seen_d;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Call sequencer
  // ----------------------------------------------------------------
  logic [sch_pkg::MS_W-1:0] ms_q;
  logic [sch_pkg::MS_W-1:0] ms_d;
  logic [1:0]               brk_q;
  logic [1:0]               brk_d;
  logic                     inb_q;
  logic                     inb_d;
  logic                     baud_q;
  logic                     baud_d;
  logic                     release_c;
  logic                     dtr_d;
  logic                     hot_d;
  logic                     ans_d;
  logic                     rel_d;
  logic                     up_d;
  logic                     abr_d;

  always_comb begin
    st_d      = st_q;
    brk_d     = brk_q;
    inb_d     = inb_q;
    baud_d    = baud_q;
    release_c = 1'b0;
    hot_d     = 1'b0;
    ans_d     = 1'b0;
    abr_d     = 1'b0;
    ms_d      = ms_q;
    if (lin.ms_tick && ms_q != sch_pkg::MS_SAT) begin
      ms_d = ms_q + 1'b1;
    end
    unique case (st_q)
      sch_pkg::ST_IDLE: begin
        brk_d  = '0;
        baud_d = 1'b0;
        if (hotline && ri_rise) begin
          hot_d = 1'b1;
          st_d  = sch_pkg::ST_DIAL;
        end else if (!hotline && !gateway && ri_rise) begin
          st_d = sch_pkg::ST_WAIT_DCD;
        end else if (gateway && dcd_rise) begin
          inb_d = 1'b1;
          st_d  = sch_pkg::ST_UP;
        end else if (!hotline && local_call) begin
          ans_d = 1'b1;
          inb_d = 1'b0;
          st_d  = gateway ? sch_pkg::ST_WAIT_DCD : sch_pkg::ST_UP;
        end
      end
      sch_pkg::ST_DIAL: begin
        if (local_drop) begin
          release_c = 1'b1;
        end else if (local_answer) begin
          st_d = sch_pkg::ST_WAIT_DCD;
        end
      end
      sch_pkg::ST_WAIT_DCD: begin
        if (local_drop) begin
          release_c = 1'b1;
        end else if (lin.dcd) begin
          st_d = sch_pkg::ST_UP;
        end else if (ms_q >= sch_pkg::DCD_WAIT_MS) begin
          release_c = 1'b1;
        end
      end
      sch_pkg::ST_UP: begin
        if (local_drop || break_long || (|line_drop)) begin
          release_c = 1'b1;
        end else if (break_short) begin
          if (brk_q == sch_pkg::SHORT_BRK_N - 2'h1) begin
            release_c = 1'b1;
          end else begin
            brk_d = brk_q + 1'b1;
          end
        end
        if (gateway && inb_q && !baud_q && cr_rx && !release_c) begin
          abr_d  = 1'b1;
          baud_d = 1'b1;
        end
      end
      sch_pkg::ST_DTR_LOW: begin
        if (ms_q >= sch_pkg::DTR_LOW_MS) begin
          st_d = sch_pkg::ST_GUARD;
        end
      end
      sch_pkg::ST_GUARD: begin
        // Timer keeps running from the release, so the guard spans both states
        if (ms_q >= sch_pkg::GUARD_MS) begin
          st_d = sch_pkg::ST_IDLE;
        end
      end
    endcase
    // Release overrides any move chosen above
    if (release_c) begin
      st_d = forced ? sch_pkg::ST_DTR_LOW : sch_pkg::ST_IDLE;
    end
    if (st_d != st_q && st_d != sch_pkg::ST_GUARD) begin
      ms_d = '0;
    end
    rel_d = release_c;
    up_d  = (st_d == sch_pkg::ST_UP);
    unique case (st_d)
      sch_pkg::ST_WAIT_DCD,
      sch_pkg::ST_UP:       dtr_d = 1'b1;
      sch_pkg::ST_DTR_LOW:  dtr_d = 1'b0;
      default:              dtr_d = forced;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q         <= sch_pkg::ST_IDLE;
      ms_q         <= '0;
      brk_q        <= '0;
      inb_q        <= 1'b0;
      baud_q       <= 1'b0;
      dtr          <= 1'b0;
      hotline_req  <= 1'b0;
      call_answer  <= 1'b0;
      call_release <= 1'b0;
      call_up      <= 1'b0;
      autobaud_req <= 1'b0;
    end else begin
      st_q         <= st_d;
      ms_q         <= ms_d;
      brk_q        <= brk_d;
      inb_q        <= inb_d;
      baud_q       <= baud_d;
      dtr          <= dtr_d;
      hotline_req  <= hot_d;
      call_answer  <= ans_d;
      call_release <= rel_d;
      call_up      <= up_d;
      autobaud_req <= abr_d;
    end
  end

endmodule

// File: test/sch_modem.sv
// Modem or gateway model on the far side of the control lines
`timescale 1ns/1ps
module sch_modem #(
  parameter int unsigned MS_CYCLES = 2
) (
  input  wire logic sys_clk,
  input  wire logic dtr,
  input  wire logic ring_en,
  input  wire logic ans,
  input  wire logic orig,
  input  wire logic dsr_off,
  output logic      dcd_pin,
  output logic      dsr_pin,
  output logic      ri_pin
);
  int   tk_q  = 0;
  int   ms_q  = 0;
  int   ans_q = 0;
  logic up_q  = 1'b0;
  always @(posedge sys_clk) begin
    tk_q <= (tk_q == MS_CYCLES - 1) ? 0 : tk_q + 1;
    if (!ring_en) ms_q <= 0;
    else if (tk_q == MS_CYCLES - 1) ms_q <= (ms_q == 5999) ? 0 : ms_q + 1;
    // Answer 10 ms after DTR, carrier follows DTR down
    if (!dtr || !ans) begin
      ans_q <= 0;
      up_q  <= 1'b0;
    end else if (tk_q == MS_CYCLES - 1) begin
      ans_q <= ans_q + 1;
      up_q  <= (ans_q >= 10);
    end
  end
  assign ri_pin  = ring_en && ms_q < 2000;
  assign dcd_pin = orig | up_q;
  assign dsr_pin = dcd_pin & !dsr_off;
endmodule

// File: test/sch_sequencer_bench.sv
// Self-checking bench of the call handshake sequencer
`timescale 1ns/1ps
module sch_sequencer_bench;
  localparam int MS = 2;
  localparam int DTR = 0, HOT = 1, ANS = 2, REL = 3, UP = 4, AB = 5;
  localparam logic [5:0] LC = 6'h01, LA = 6'h02, LD = 6'h04, BL = 6'h08, BS = 6'h10, CR = 6'h20;
  logic       sys_clk = 1'b0;
  logic       rst_n   = 1'b0;
  logic [3:0] mode    = 4'h0;
  logic [5:0] ev      = 6'h00;
  logic       ring_en = 1'b0, ans = 1'b0, orig = 1'b0, dsr_off = 1'b0;
  wire        dcd_pin, dsr_pin, ri_pin;
  wire  [5:0] o;
  int         fail_count = 0, samples_checked = 0, seed = 79384, n = 0;

  sch_sequencer #(.MS_CYCLES(MS)) u_sch_sequencer (
    .sys_clk(sys_clk), .rst_n(rst_n), .mode(mode), .dcd_pin(dcd_pin),
    .dsr_pin(dsr_pin), .ri_pin(ri_pin), .local_call(ev[0]), .local_answer(ev[1]),
    .local_drop(ev[2]), .break_long(ev[3]), .break_short(ev[4]), .cr_rx(ev[5]),
    .dtr(o[0]), .hotline_req(o[1]), .call_answer(o[2]), .call_release(o[3]),
    .call_up(o[4]), .autobaud_req(o[5]));
  sch_modem #(.MS_CYCLES(MS)) u_sch_modem (
    .sys_clk(sys_clk), .dtr(o[0]), .ring_en(ring_en), .ans(ans), .orig(orig),
    .dsr_off(dsr_off), .dcd_pin(dcd_pin), .dsr_pin(dsr_pin), .ri_pin(ri_pin));

  // ------
  // Tasks
  // ------
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_rng(input int lo, input int hi, input int g);
    samples_checked++;
    if (g < lo || g > hi) begin
      fail_count++;
      $display("Error t=%0t exp=%h..%h got=%h", $time, lo, hi, g);
    end
  endtask
  task automatic wt(input int b, input logic v, input int lim, output int c);
    c = 0;
    do begin
      @(negedge sys_clk);
      c++;
    end while (o[b] !== v && c < lim);
  endtask
  task automatic pls(input logic [5:0] m);
    @(posedge sys_clk) ev <= m;
    @(posedge sys_clk) ev <= 6'h00;
  endtask
  task automatic rst(input logic [3:0] m);
    @(posedge sys_clk) begin
      mode  <= m;
      rst_n <= 1'b0;
    end
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic ring_dial();
    @(posedge sys_clk) ring_en <= 1'b1;
    wt(HOT, 1'b1, 100, n);
    chk(1'b1, o[HOT]);
    @(posedge sys_clk) ring_en <= 1'b0;
    repeat ($unsigned($random(seed)) % 16) @(posedge sys_clk);
  endtask
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ------
  // Clock, watchdog, tests
  // ------
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (98000) @(posedge sys_clk);
    fail_count++;
    give_verdict();
  end
  initial begin
    rst(4'h3);
    chk(1'b1, o[DTR]);
    rst(4'h1);
    chk(1'b0, o[DTR]);
    ring_dial();
    chk(1'b0, o[DTR]);
    ans <= 1'b1;
    pls(LA);
    wt(DTR, 1'b1, 4, n);
    chk(1'b1, o[DTR]);
    wt(UP, 1'b1, 30 * MS, n);
    chk(1'b1, o[UP]);
    pls(BS);
    pls(BS);
    wt(REL, 1'b1, 4, n);
    chk(1'b0, o[REL]);
    pls(BS);
    wt(REL, 1'b1, 4, n);
    chk(1'b1, o[REL]);
    chk(1'b0, o[DTR]);
    ans <= 1'b0;
    ring_dial();
    pls(LA);
    wt(DTR, 1'b1, 4, n);
    wt(REL, 1'b1, 36000 * MS, n);
    chk_rng(34999 * MS, 35001 * MS + 6, n);
    $display("test hotline done");
    rst(4'h3);
    ring_dial();
    chk(1'b1, o[DTR]);
    ans <= 1'b1;
    pls(LA);
    wt(UP, 1'b1, 30 * MS, n);
    chk(1'b1, o[DTR]);
    repeat (120 * MS) @(posedge sys_clk);
    pls(LD);
    wt(REL, 1'b1, 4, n);
    chk(1'b0, o[DTR]);
    ans     <= 1'b0;
    wt(DTR, 1'b1, 300 * MS, n);
    chk_rng(199 * MS, 201 * MS + 4, n);
    // Ring rises inside the guard, after DTR is back
    ring_en <= 1'b1;
    wt(HOT, 1'b1, 1700 * MS, n);
    chk(1'b0, o[HOT]);
    wt(HOT, 1'b1, 4500 * MS, n);
    chk(1'b1, o[HOT]);
    $display("test forced hotline done");
    ring_en <= 1'b0;
    rst(4'h2);
    pls(LC);
    wt(UP, 1'b1, 4, n);
    chk(1'b1, o[DTR]);
    pls(BL);
    wt(REL, 1'b1, 4, n);
    chk(1'b0, o[DTR]);
    $display("test forced pool done");
    rst(4'h0);
    ans <= 1'b1;
    @(posedge sys_clk) ring_en <= 1'b1;
    wt(UP, 1'b1, 30 * MS, n);
    chk(1'b1, o[UP]);
    @(posedge sys_clk) ring_en <= 1'b0;
    ans <= 1'b0;
    wt(REL, 1'b1, 60 * MS, n);
    chk(1'b0, o[REL]);
    @(posedge sys_clk) ans <= 1'b1;
    repeat (150 * MS + $unsigned($random(seed)) % 64) @(posedge sys_clk);
    ans <= 1'b0;
    wt(REL, 1'b1, 8, n);
    chk(1'b1, o[REL]);
    chk(1'b0, o[DTR]);
    $display("test pool done");
    rst(4'h4);
    @(posedge sys_clk) orig <= 1'b1;
    wt(UP, 1'b1, 10, n);
    chk(1'b1, o[DTR]);
    pls(CR);
    wt(AB, 1'b1, 4, n);
    chk(1'b1, o[AB]);
    pls(CR);
    wt(AB, 1'b1, 4, n);
    chk(1'b0, o[AB]);
    @(posedge sys_clk) orig <= 1'b0;
    repeat (50 * MS) @(posedge sys_clk);
    orig <= 1'b1;
    wt(REL, 1'b1, 60 * MS, n);
    chk(1'b0, o[REL]);
    @(posedge sys_clk) dsr_off <= 1'b1;
    wt(REL, 1'b1, 110 * MS, n);
    chk_rng(99 * MS, 101 * MS + 6, n);
    chk(1'b0, o[DTR]);
    @(posedge sys_clk) orig <= 1'b0;
    dsr_off <= 1'b0;
    repeat (10) @(posedge sys_clk);
    orig <= 1'b1;
    wt(UP, 1'b1, 10, n);
    @(posedge sys_clk) orig <= 1'b0;
    wt(REL, 1'b1, 110 * MS, n);
    chk_rng(99 * MS, 101 * MS + 6, n);
    pls(LC);
    wt(ANS, 1'b1, 4, n);
    chk(1'b1, o[ANS]);
    chk(1'b1, o[DTR]);
    chk(1'b0, o[UP]);
    ans <= 1'b1;
    wt(UP, 1'b1, 30 * MS, n);
    chk(1'b1, o[UP]);
    pls(LD);
    wt(REL, 1'b1, 4, n);
    chk(1'b0, o[DTR]);
    $display("test gateway done");
    give_verdict();
  end
endmodule

// File: test/sch_sequencer_props.sv
// Port checker of the call handshake sequencer
`timescale 1ns/1ps
module sch_sequencer_props #(
  parameter int unsigned MS_CYCLES = 2
) (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [3:0] mode,
  input wire logic       dcd_pin,
  input wire logic       dsr_pin,
  input wire logic       ri_pin,
  input wire logic       local_call,
  input wire logic       local_answer,
  input wire logic       local_drop,
  input wire logic       break_long,
  input wire logic       break_short,
  input wire logic       cr_rx,
  input wire logic       dtr,
  input wire logic       hotline_req,
  input wire logic       call_answer,
  input wire logic       call_release,
  input wire logic       call_up,
  input wire logic       autobaud_req
);
  localparam int DLO = 199 * MS_CYCLES;
  localparam int DHI = 201 * MS_CYCLES + 4;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_hot_single: assert property (hotline_req |=> !hotline_req)
    else $error("hotline request longer than one cycle");
  a_hot_dtr_off: assert property (hotline_req && mode == 4'h1 |-> !dtr)
    else $error("DTR high while dialling");
  a_hot_dtr_cause: assert property ($rose(dtr) && mode == 4'h1 |-> $past(local_answer))
    else $error("DTR rose without answer");
  a_rel_dtr_low: assert property (call_release && mode inside {4'h0, 4'h1, 4'h4} |-> !dtr)
    else $error("DTR high at release");
  a_frc_dtr_pulse: assert property (call_release && mode inside {4'h2, 4'h3}
    |-> !dtr ##1 !dtr [*8])
    else $error("forced DTR low pulse too short");
  a_frc_dtr_back: assert property (call_release && mode inside {4'h2, 4'h3}
    |-> ##[DLO:DHI] dtr)
    else $error("forced DTR not restored");
  a_drop_release: assert property (call_up && local_drop |=> call_release && !call_up)
    else $error("drop did not release");
  a_break_release: assert property (call_up && break_long |=> call_release && !dtr)
    else $error("long break did not release");
  a_gw_up_dtr: assert property (call_up && mode == 4'h4 |-> dtr)
    else $error("gateway call up without DTR");
  a_baud_cause: assert property (autobaud_req |-> mode == 4'h4 && call_up && $past(cr_rx))
    else $error("autobaud without return in gateway call");

  c_frc_release: cover property (call_release && mode == 4'h3);
  c_autobaud: cover property (autobaud_req);
  c_hotline: cover property (hotline_req);
endmodule

bind sch_sequencer sch_sequencer_props #(.MS_CYCLES(MS_CYCLES)) u_sch_sequencer_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .mode(mode), .dcd_pin(dcd_pin), .dsr_pin(dsr_pin),
  .ri_pin(ri_pin), .local_call(local_call), .local_answer(local_answer),
  .local_drop(local_drop), .break_long(break_long), .break_short(break_short),
  .cr_rx(cr_rx), .dtr(dtr), .hotline_req(hotline_req), .call_answer(call_answer),
  .call_release(call_release), .call_up(call_up), .autobaud_req(autobaud_req));
